/* rtl/fn_cfg_pkg.sv */
/*
 * Shared constants for the fractional-N frequency word link: word layout,
 * denominator table, reference divider codes, link timing and host registers.
 * Assumes both ends and the bench import this package.
 */
package fn_cfg_pkg;
    localparam int          WORD_W       = 24;
    localparam int          TX_BIT       = 23;
    localparam int          PD_BIT       = 22;
    localparam int          FAST_BIT     = 21;
    localparam int          SPARE_BIT    = 20;
    localparam int          BAND_BIT     = 19;
    localparam int          MAIN_MSB     = 18;
    localparam int          MAIN_LSB     = 15;
    localparam int          SWAL_MSB     = 14;
    localparam int          SWAL_LSB     = 12;
    localparam int          FRAC_MSB     = 11;
    localparam int          FRAC_LSB     = 2;
    localparam int          ADDR_MSB     = 1;
    localparam logic [1:0]  ADDR_FREQ    = 2'h0;
    localparam logic [23:0] WORD_RESET   = 24'h000000;

    localparam logic [1:0]  REF_12M6     = 2'h0;
    localparam logic [1:0]  REF_14M4     = 2'h1;
    localparam logic [1:0]  REF_25M2     = 2'h2;
    localparam logic [1:0]  REF_DIV_ONE  = 2'h1;
    localparam logic [1:0]  REF_DIV_TWO  = 2'h2;

    localparam logic [9:0]  DEN_RX_12M6  = 10'h1f8;
    localparam logic [9:0]  DEN_RX_14M4  = 10'h240;
    localparam logic [9:0]  DEN_RX_26M0  = 10'h208;
    localparam logic [9:0]  DEN_TXL_12M6 = 10'h276;
    localparam logic [9:0]  DEN_TXL_14M4 = 10'h2d0;
    localparam logic [9:0]  DEN_TXL_26M0 = 10'h28a;
    localparam logic [9:0]  DEN_TXH_12M6 = 10'h237;
    localparam logic [9:0]  DEN_TXH_14M4 = 10'h288;
    localparam logic [9:0]  DEN_TXH_26M0 = 10'h249;

    localparam logic [3:0]  MAIN_MIN     = 4'h2;
    localparam logic [2:0]  SWAL_MAX_HI  = 3'h7;
    localparam logic [2:0]  SWAL_MAX_LO  = 3'h3;

    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          SCLK_PERIOD_NS = 320;
    localparam int          HALF_CYC       = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [3:0]  HALF_LAST      = 4'(HALF_CYC - 1);
    localparam logic [4:0]  LAST_BIT       = 5'(WORD_W - 1);

    localparam logic [7:0]  OFS_WORD     = 8'h00;
    localparam logic [7:0]  OFS_STATUS   = 8'h04;
    localparam logic [7:0]  OFS_CHIP_EN  = 8'h08;
    localparam int          ST_BUSY      = 0;
    localparam int          ST_RANGE     = 1;
    localparam int          ST_COUNT_LSB = 8;

    typedef enum {HOST_IDLE, HOST_LOW, HOST_HIGH, HOST_SETUP, HOST_LATCH} host_state_t;
endpackage

/* rtl/fn_host_end.sv */
/*
 * Host end: a classic Wishbone slave that takes 24-bit words and sends
 * them over the three-wire link, then pulses latch enable.
 * Assumes the link clock is made here by dividing CLK_I.
 */
`timescale 1ns/1ps
module fn_host_end (
    input  wire logic         CLK_I,
    input  wire logic         RST_I,
    input  wire logic [7:0]   ADR_I,
    input  wire logic [31:0]  DAT_I,
    output logic      [31:0]  DAT_O,
    input  wire logic         WE_I,
    input  wire logic [3:0]   SEL_I,
    input  wire logic         CYC_I,
    input  wire logic         STB_I,
    output logic              ACK_O,
    fn_link_if.host           LINK
);
    import fn_cfg_pkg::*;

    typedef struct packed {
        host_state_t state;
        logic [3:0]  div;
        logic [4:0]  bit_idx;
        logic [23:0] tx_word;
        logic [23:0] shift;
        logic        sclk;
        logic        sdata;
        logic        le;
        logic        ce;
        logic        range_warn;
        logic [7:0]  sent;
        logic        ack;
        logic [31:0] rdata;
    } host_state_reg_t;

    host_state_reg_t s_reg;
    host_state_reg_t s_next;

    always_comb begin
        logic        req;
        logic [23:0] merged;
        logic [3:0]  m;
        logic [2:0]  a;
        req    = CYC_I && STB_I && !s_reg.ack;
        merged = s_reg.tx_word;
        m      = '0;
        a      = '0;
        s_next = s_reg;
        s_next.ack   = req;
        s_next.rdata = '0;
        for (int i = 0; i < 3; i++) begin
            if (SEL_I[i]) begin
                merged[i*8 +: 8] = DAT_I[i*8 +: 8];
            end
        end
        merged[SPARE_BIT] = 1'b0;
        m = merged[MAIN_MSB:MAIN_LSB];
        a = merged[SWAL_MSB:SWAL_LSB];
        if (req && !WE_I) begin
            if (ADR_I == OFS_WORD) begin
                s_next.rdata = {8'h00, s_reg.tx_word};
            end else if (ADR_I == OFS_STATUS) begin
                s_next.rdata = {16'h0000, s_reg.sent, 6'h00, s_reg.range_warn, s_reg.state != HOST_IDLE};
            end else if (ADR_I == OFS_CHIP_EN) begin
                s_next.rdata = {31'h00000000, s_reg.ce};
            end
        end
        if (req && WE_I) begin
            if (ADR_I == OFS_CHIP_EN && SEL_I[0]) begin
                s_next.ce = DAT_I[0];
            end else if (ADR_I == OFS_WORD && s_reg.state == HOST_IDLE) begin
                // any word may be sent alone
                s_next.tx_word = merged;
                s_next.shift   = merged;
                s_next.sdata   = merged[WORD_W-1];
                s_next.bit_idx = '0;
                s_next.div     = '0;
                s_next.state   = HOST_LOW;
                // Range checks only matter for frequency words.
                // range warning
                s_next.range_warn = (merged[ADDR_MSB:0] == ADDR_FREQ) &&
                    (m < MAIN_MIN || a > (merged[BAND_BIT] ? SWAL_MAX_HI : SWAL_MAX_LO) ||
                     10'(merged[FRAC_MSB:FRAC_LSB]) > 10'(DEN_TXL_14M4));
            end
        end
        s_next.div = (s_reg.div == HALF_LAST) ? '0 : s_reg.div + 4'h1;
        case (s_reg.state)
            HOST_IDLE: begin
                s_next.div = '0;
            end
            HOST_LOW: begin
                if (s_reg.div == HALF_LAST) begin
                    s_next.sclk  = 1'b1;
                    s_next.state = HOST_HIGH;
                end
            end
            HOST_HIGH: begin
                if (s_reg.div == HALF_LAST) begin
                    s_next.sclk = 1'b0;
                    if (s_reg.bit_idx == LAST_BIT) begin
                        s_next.state = HOST_SETUP;
                    end else begin
                        s_next.shift   = {s_reg.shift[WORD_W-2:0], 1'b0};
                        s_next.sdata   = s_reg.shift[WORD_W-2];
                        s_next.bit_idx = s_reg.bit_idx + 5'h1;
                        s_next.state   = HOST_LOW;
                    end
                end
            end
            HOST_SETUP: begin
                if (s_reg.div == HALF_LAST) begin
                    s_next.le    = 1'b1;
                    s_next.state = HOST_LATCH;
                end
            end
            HOST_LATCH: begin
                if (s_reg.div == HALF_LAST) begin
                    s_next.le    = 1'b0;
                    s_next.sent  = s_reg.sent + 8'h01;
                    s_next.state = HOST_IDLE;
                end
            end
            default: begin
                s_next.state = HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_reg       <= '0;
            s_reg.state <= HOST_IDLE;
            s_reg.ce    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign DAT_O                 = s_reg.rdata;
    assign ACK_O                 = s_reg.ack;
    assign LINK.sclk             = s_reg.sclk;
    assign LINK.sdata            = s_reg.sdata;
    assign LINK.latch_enable_pin = s_reg.le;
    assign LINK.chip_enable      = s_reg.ce;
endmodule

/* rtl/fn_link_if.sv */
/*
 * Three-wire programming link plus the chip enable pin.
 * Assumes the host end drives every wire and the synthesizer end only listens.
 */
`timescale 1ns/1ps
interface fn_link_if;
    logic sclk;
    logic sdata;
    logic latch_enable_pin;
    logic chip_enable;

    modport device (input sclk, input sdata, input latch_enable_pin, input chip_enable);
    modport host   (output sclk, output sdata, output latch_enable_pin, output chip_enable);
endinterface

/* rtl/fn_synth_end.sv */
/*
 * Synthesizer end: receives the serial frequency word, keeps the frequency
 * control register and derives divider settings from it.
 * Assumes CLK_I is much faster than the link clock; every link wire and the
 * reference select input are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
module fn_synth_end (
    input  wire logic                  CLK_I,
    input  wire logic                  RST_I,
    fn_link_if.device                  LINK,
    input  wire logic [1:0]            REFCLK_SELECT_I,
    output logic                       TX_SELECT_O,
    output logic                       SYNTH_POWER_DOWN_O,
    output logic                       HIGH_BAND_ENABLE_O,
    output logic                       LOW_BAND_ENABLE_O,
    output logic                       FAST_LOCK_SELECT_O,
    output logic                       BAND_SELECT_O,
    output logic [3:0]                 MAIN_DIVIDE_COUNT_O,
    output logic [2:0]                 SWALLOW_COUNT_O,
    output logic [9:0]                 FRACTION_NUMERATOR_O,
    output logic [9:0]                 FRACTION_DENOMINATOR_O,
    output logic [1:0]                 REF_DIVIDER_O,
    output logic [6:0]                 INTEGER_RATIO_O,
    output logic                       RATIO_INVALID_O,
    output logic                       WORD_LOADED_O,
    output logic                       WORD_SKIPPED_O
);
    import fn_cfg_pkg::*;

    typedef struct packed {
        logic        sclk_meta;
        logic        sclk_sync;
        logic        sclk_prev;
        logic        data_meta;
        logic        data_sync;
        logic        le_meta;
        logic        le_sync;
        logic        le_prev;
        logic        ce_meta;
        logic        ce_sync;
        logic [1:0]  ref_meta;
        logic [1:0]  ref_sync;
        logic [23:0] shift;
        logic [23:0] word;
        logic        tx;
        logic        power_down;
        logic        high_en;
        logic        low_en;
        logic        fast;
        logic        band;
        logic [3:0]  main_cnt;
        logic [2:0]  swal_cnt;
        logic [9:0]  frac_num;
        logic [9:0]  frac_den;
        logic [1:0]  ref_div;
        logic [6:0]  int_ratio;
        logic        invalid;
        logic        loaded;
        logic        skipped;
    } dev_state_t;

    dev_state_t state_reg;
    dev_state_t state_next;

    // Denominator table indexed by transmit, band and reference select.
    function automatic logic [9:0] denominator(input logic tx, input logic band, input logic [1:0] refsel);
        logic [9:0] den;
        den = DEN_RX_26M0;
        if (!tx) begin
            if (refsel == REF_12M6 || refsel == REF_25M2) begin
                den = DEN_RX_12M6;
            end else if (refsel == REF_14M4) begin
                den = DEN_RX_14M4;
            end else begin
                den = DEN_RX_26M0;
            end
        end else if (!band) begin
            if (refsel == REF_12M6 || refsel == REF_25M2) begin
                den = DEN_TXL_12M6;
            end else if (refsel == REF_14M4) begin
                den = DEN_TXL_14M4;
            end else begin
                den = DEN_TXL_26M0;
            end
        end else begin
            if (refsel == REF_12M6 || refsel == REF_25M2) begin
                den = DEN_TXH_12M6;
            end else if (refsel == REF_14M4) begin
                den = DEN_TXH_14M4;
            end else begin
                den = DEN_TXH_26M0;
            end
        end
        return den;
    endfunction

    function automatic logic [1:0] ref_divider(input logic [1:0] refsel);
        return (refsel == REF_12M6 || refsel == REF_14M4) ? REF_DIV_ONE : REF_DIV_TWO;
    endfunction

    always_comb begin
        state_next = state_reg;
        state_next.sclk_meta = LINK.sclk;
        state_next.sclk_sync = state_reg.sclk_meta;
        state_next.sclk_prev = state_reg.sclk_sync;
        state_next.data_meta = LINK.sdata;
        state_next.data_sync = state_reg.data_meta;
        state_next.le_meta   = LINK.latch_enable_pin;
        state_next.le_sync   = state_reg.le_meta;
        state_next.le_prev   = state_reg.le_sync;
        state_next.ce_meta   = LINK.chip_enable;
        state_next.ce_sync   = state_reg.ce_meta;
        state_next.ref_meta  = REFCLK_SELECT_I;
        state_next.ref_sync  = state_reg.ref_meta;
        state_next.loaded    = 1'b0;
        state_next.skipped   = 1'b0;

        if (state_reg.sclk_sync && !state_reg.sclk_prev) begin
            state_next.shift = {state_reg.shift[WORD_W-2:0], state_reg.data_sync};
        end

        // The shift path ignores chip enable, so a powered-down part still takes writes.
        // writes while disabled
        if (state_reg.le_sync && !state_reg.le_prev) begin
            if (state_reg.shift[ADDR_MSB:0] == ADDR_FREQ) begin
                state_next.word   = state_reg.shift;
                state_next.loaded = 1'b1;
            end else begin
                state_next.skipped = 1'b1;
            end
        end

        // Word fields come from the next word so they move in one edge; frac_den, ref_div and power_down also follow ref_sync and ce_sync.
        // settings change together
        state_next.tx = state_next.word[TX_BIT];
        state_next.fast = state_next.word[FAST_BIT];
        state_next.band = state_next.word[BAND_BIT];
        state_next.power_down = state_next.word[PD_BIT] || !state_reg.ce_sync;
        state_next.high_en    = state_next.band && !state_next.power_down;
        state_next.low_en     = !state_next.band && !state_next.power_down;
        state_next.main_cnt = state_next.word[MAIN_MSB:MAIN_LSB];
        state_next.swal_cnt = state_next.word[SWAL_MSB:SWAL_LSB];
        state_next.frac_num = state_next.word[FRAC_MSB:FRAC_LSB];
        state_next.frac_den = denominator(state_next.tx, state_next.band, state_reg.ref_sync);
        state_next.ref_div = ref_divider(state_reg.ref_sync);
        if (state_next.band) begin
            state_next.int_ratio = {state_next.main_cnt, 3'h0} + 7'(state_next.swal_cnt);
        end else begin
            state_next.int_ratio = 7'({state_next.main_cnt, 2'h0}) + 7'(state_next.swal_cnt);
        end
        state_next.invalid = (7'(state_next.swal_cnt) >= 7'(state_next.main_cnt));
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_reg       <= '0;
            state_reg.word  <= WORD_RESET;
            // The reset word decodes as receive with code 00, so show that decode from the first edge.
            state_reg.frac_den <= DEN_RX_12M6;
            state_reg.ref_div  <= REF_DIV_ONE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign TX_SELECT_O            = state_reg.tx;
    assign SYNTH_POWER_DOWN_O     = state_reg.power_down;
    assign HIGH_BAND_ENABLE_O     = state_reg.high_en;
    assign LOW_BAND_ENABLE_O      = state_reg.low_en;
    assign FAST_LOCK_SELECT_O     = state_reg.fast;
    assign BAND_SELECT_O          = state_reg.band;
    assign MAIN_DIVIDE_COUNT_O    = state_reg.main_cnt;
    assign SWALLOW_COUNT_O        = state_reg.swal_cnt;
    assign FRACTION_NUMERATOR_O   = state_reg.frac_num;
    assign FRACTION_DENOMINATOR_O = state_reg.frac_den;
    assign REF_DIVIDER_O          = state_reg.ref_div;
    assign INTEGER_RATIO_O        = state_reg.int_ratio;
    assign RATIO_INVALID_O        = state_reg.invalid;
    assign WORD_LOADED_O          = state_reg.loaded;
    assign WORD_SKIPPED_O         = state_reg.skipped;
endmodule

/* verification/fn_link_checker.sv */
/* Concurrent checks on the frequency word link and the synthesizer outputs.
   Assumes tb_top instantiates it beside the link interface, one clock domain. */
`timescale 1ns/1ps
module fn_link_checker (
    input wire logic       CLK_I,
    input wire logic       RST_I,
    input wire logic       sclk,
    input wire logic       latch_enable_pin,
    input wire logic       chip_enable,
    input wire logic       TX_SELECT_O,
    input wire logic       SYNTH_POWER_DOWN_O,
    input wire logic       HIGH_BAND_ENABLE_O,
    input wire logic       BAND_SELECT_O,
    input wire logic [3:0] MAIN_DIVIDE_COUNT_O,
    input wire logic [2:0] SWALLOW_COUNT_O,
    input wire logic [9:0] FRACTION_DENOMINATOR_O,
    input wire logic [1:0] REF_DIVIDER_O,
    input wire logic [6:0] INTEGER_RATIO_O,
    input wire logic       RATIO_INVALID_O,
    input wire logic       WORD_LOADED_O,
    input wire logic       WORD_SKIPPED_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    a_ratio_high_band: assert property (BAND_SELECT_O |->
        INTEGER_RATIO_O == {MAIN_DIVIDE_COUNT_O, 3'h0} + SWALLOW_COUNT_O) else $error("high band ratio wrong");
    a_ratio_low_band: assert property (!BAND_SELECT_O |->
        INTEGER_RATIO_O == {1'h0, MAIN_DIVIDE_COUNT_O, 2'h0} + SWALLOW_COUNT_O) else $error("low band ratio wrong");
    a_invalid_flag: assert property (WORD_LOADED_O |=>
        RATIO_INVALID_O == (SWALLOW_COUNT_O >= MAIN_DIVIDE_COUNT_O)) else $error("ratio flag wrong");
    a_den_receive: assert property (!TX_SELECT_O |->
        FRACTION_DENOMINATOR_O inside {10'h1f8, 10'h240, 10'h208}) else $error("receive denominator wrong");
    a_den_tx_low: assert property (TX_SELECT_O && !BAND_SELECT_O |->
        FRACTION_DENOMINATOR_O inside {10'h276, 10'h2d0, 10'h28a}) else $error("low band denominator wrong");
    a_den_tx_high: assert property (TX_SELECT_O && BAND_SELECT_O |->
        FRACTION_DENOMINATOR_O inside {10'h237, 10'h288, 10'h249}) else $error("high band denominator wrong");
    a_ref_divider: assert property (FRACTION_DENOMINATOR_O inside {10'h208, 10'h28a, 10'h249} |->
        REF_DIVIDER_O == 2'h2) else $error("reference divider wrong");
    a_band_enable: assert property (HIGH_BAND_ENABLE_O == (BAND_SELECT_O && !SYNTH_POWER_DOWN_O))
        else $error("band enable wrong");
    a_ce_power_down: assert property (!chip_enable [*4] |-> SYNTH_POWER_DOWN_O)
        else $error("chip enable low but powered");
    a_change_on_load: assert property ($changed(TX_SELECT_O) || $changed(MAIN_DIVIDE_COUNT_O) |->
        WORD_LOADED_O) else $error("outputs changed without load");
    a_latch_answer: assert property ($rose(latch_enable_pin) |->
        ##[2:6] (WORD_LOADED_O || WORD_SKIPPED_O)) else $error("latch not answered");
    a_latch_sclk_low: assert property (latch_enable_pin |-> !sclk)
        else $error("latch while link clock high");
    a_sclk_high_len: assert property ($rose(sclk) |-> sclk [*3])
        else $error("link clock high too short");
endmodule

/* verification/tb_top.sv */
/* Bench: writes words through the host end over Wishbone, checks the synth end.
   Assumes both ends face each other through fn_link_if. */
`timescale 1ns/1ps
module tb_top;
    import fn_cfg_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h0, dat_r, rd;
    logic [1:0]  ref_sel = 2'h0, rdiv;
    logic        tx, pd, hbe, lbe, fast, band, inv, loaded, skipped, sclk_d = 1'b0, le_d = 1'b0;
    logic [3:0]  main_c;
    logic [2:0]  swal;
    logic [9:0]  frac, den;
    logic [6:0]  ratio;
    logic [23:0] shreg = 24'h0, sent = 24'h0, w, w2;
    logic [9:0]  dt [3][4] = '{'{10'h1f8, 10'h240, 10'h1f8, 10'h208},
        '{10'h276, 10'h2d0, 10'h276, 10'h28a}, '{10'h237, 10'h288, 10'h237, 10'h249}};
    int          num_errors = 0, total_checks = 0, n_load = 0, n_skip = 0, i;
    fn_link_if link();
    fn_host_end i_fn_host_end (.CLK_I(clk), .RST_I(rst), .ADR_I(adr), .DAT_I(dat_w), .DAT_O(dat_r),
        .WE_I(we), .SEL_I(4'hf), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .LINK(link));
    fn_synth_end i_fn_synth_end (.CLK_I(clk), .RST_I(rst), .LINK(link), .REFCLK_SELECT_I(ref_sel),
        .TX_SELECT_O(tx), .SYNTH_POWER_DOWN_O(pd), .HIGH_BAND_ENABLE_O(hbe), .LOW_BAND_ENABLE_O(lbe),
        .FAST_LOCK_SELECT_O(fast), .BAND_SELECT_O(band), .MAIN_DIVIDE_COUNT_O(main_c),
        .SWALLOW_COUNT_O(swal), .FRACTION_NUMERATOR_O(frac), .FRACTION_DENOMINATOR_O(den),
        .REF_DIVIDER_O(rdiv), .INTEGER_RATIO_O(ratio), .RATIO_INVALID_O(inv), .WORD_LOADED_O(loaded),
        .WORD_SKIPPED_O(skipped));
    fn_link_checker i_chk (.CLK_I(clk), .RST_I(rst), .sclk(link.sclk), .latch_enable_pin(link.latch_enable_pin),
        .chip_enable(link.chip_enable), .TX_SELECT_O(tx), .SYNTH_POWER_DOWN_O(pd), .HIGH_BAND_ENABLE_O(hbe),
        .BAND_SELECT_O(band), .MAIN_DIVIDE_COUNT_O(main_c), .SWALLOW_COUNT_O(swal),
        .FRACTION_DENOMINATOR_O(den), .REF_DIVIDER_O(rdiv), .INTEGER_RATIO_O(ratio),
        .RATIO_INVALID_O(inv), .WORD_LOADED_O(loaded), .WORD_SKIPPED_O(skipped));

    initial begin
        forever #20 clk = ~clk;
    end

    // Rebuilds the shifted word as the far end would see it at each latch.
    always @(posedge clk) begin
        sclk_d <= link.sclk;
        le_d <= link.latch_enable_pin;
        if (link.sclk && !sclk_d) shreg <= {shreg[22:0], link.sdata};
        if (link.latch_enable_pin && !le_d) sent <= shreg;
        if (loaded === 1'b1) n_load++;
        if (skipped === 1'b1) n_skip++;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic wr);
        int k;
        @(posedge clk);
        adr <= a;
        dat_w <= d;
        we <= wr;
        cyc <= 1'b1;
        stb <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (k == 50) begin
            num_errors++;
            stop_test();
        end
    endtask

    // Polls busy instead of counting cycles, so the link pace may change.
    task automatic send(input logic [23:0] v, input logic [1:0] r);
        int k;
        ref_sel <= r;
        wb(OFS_WORD, {8'h00, v}, 1'b1);
        for (k = 0; k < 200; k++) begin
            wb(OFS_STATUS, 32'h0, 1'b0);
            if (rd[ST_BUSY] === 1'b0) break;
        end
        if (k == 200) begin
            num_errors++;
            stop_test();
        end
        repeat (4) @(posedge clk);
        chk(sent, v & 24'hefffff, "shifted word");
    endtask

    task automatic expect_word(input logic [23:0] v, input logic [1:0] r, input logic ce);
        logic off;
        int m;
        off = v[22] | ~ce;
        m = v[23] ? (v[19] ? 2 : 1) : 0;
        chk(tx, v[23], "tx select");
        chk(pd, off, "power down");
        chk({band, hbe, lbe}, {v[19], v[19] & ~off, ~v[19] & ~off}, "band");
        chk(fast, v[21], "fast lock");
        chk({main_c, swal, frac}, v[18:2], "divider fields");
        chk(ratio, 7'((v[19] ? 8 : 4) * v[18:15] + v[14:12]), "ratio");
        chk(inv, v[14:12] >= v[18:15], "ratio flag");
        chk(den, dt[m][r], "denominator");
        chk(rdiv, r[1] ? 2'h2 : 2'h1, "ref divider");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(den, 10'h1f8, "reset denominator");
        for (i = 0; i < 16; i++) begin
            w = {i[3], i[0], i[1], 1'b0, i[2], 4'(15 - i / 2), i[2] ? 3'(i) : 3'(i % 4), 10'(i * 30), 2'h0};
            send(w, 2'(i));
            expect_word(w, 2'(i), 1'b1);
            chk(n_load, i + 1, "load count");
        end
        $display("mode table test done");
        for (i = 1; i < 4; i++) begin
            send({~w[23:2], 2'(i)}, 2'h3);
        end
        expect_word(w, 2'h3, 1'b1);
        chk({n_skip[15:0], n_load[15:0]}, {16'd3, 16'd16}, "skip count");
        $display("address test done");
        wb(OFS_CHIP_EN, 32'h0, 1'b1);
        w2 = {5'h01, 4'h3, 3'h5, 10'h3e8, 2'h0};
        send(w2, 2'h2);
        expect_word(w2, 2'h2, 1'b0);
        wb(OFS_CHIP_EN, 32'h1, 1'b1);
        repeat (6) @(posedge clk);
        expect_word(w2, 2'h2, 1'b1);
        $display("chip enable test done");
        wb(OFS_STATUS, 32'h0, 1'b0);
        chk(rd[15:0], 16'h1402, "status");
        wb(8'h40, 32'hffffffff, 1'b1);
        wb(8'h40, 32'h0, 1'b0);
        chk(rd, 32'h0, "unmapped read");
        wb(OFS_CHIP_EN, 32'h0, 1'b0);
        chk(rd, 32'h1, "chip enable read");
        $display("host register test done");
        stop_test();
    end
endmodule
